// >>> inc/e1ram_pkg.sv
package e1ram_pkg;
   // ------------------------------------------------------------
   // Register indices and byte addresses (index times four)
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_STATUS = 8'h06;
   localparam logic [7:0] IDX_CTRL   = 8'h10;
   localparam logic [7:0] IDX_MASK   = 8'h16;
   localparam logic [7:0] IDX_SYNC   = 8'h1E;
   localparam logic [7:0] A_STATUS   = {IDX_STATUS[5:0], 2'b00};
   localparam logic [7:0] A_CTRL     = {IDX_CTRL[5:0], 2'b00};
   localparam logic [7:0] A_MASK     = {IDX_MASK[5:0], 2'b00};
   localparam logic [7:0] A_SYNC     = {IDX_SYNC[5:0], 2'b00};
   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int SB_LOS  = 0;
   localparam int SB_CL   = 1;
   localparam int SB_FEA  = 2;
   localparam int SB_UA1  = 3;
   localparam int SB_SLIP = 4;
   localparam int SB_SA0  = 5;
   localparam int SB_DMA  = 6;
   localparam int SB_SA1  = 7;
   localparam int CB_CRC4   = 0;
   localparam int CB_EXTCL  = 1;
   localparam int CB_CLTEST = 2;
   localparam logic [7:0] CTRL_BITS = 8'h07;
   localparam logic [7:0] CTRL_RST  = 8'h00;
   localparam logic [7:0] MASK_RST  = 8'h00;
   // Timeslot bit n sits at index 8-n
   localparam int TS16_DMA_POS = 2;
   localparam int NAF_FEA_POS  = 5;
   localparam logic [3:0] MF_LAST = 4'hF;
   // ------------------------------------------------------------
   // Alarm criteria and timing
   // ------------------------------------------------------------
   localparam logic [11:0] CL_ZEROS_STD = 12'h0FF;
   localparam logic [11:0] CL_ZEROS_EXT = 12'h800;
   localparam logic [7:0]  CL_WIN_LAST  = 8'hFE;
   localparam logic [5:0]  CL_ONES_REL  = 6'h20;
   localparam logic [8:0]  UA_WIN_LAST  = 9'h1FF;
   localparam logic [1:0]  UA_ZEROS     = 2'h3;
   localparam logic [1:0]  SA1_ZEROS    = 2'h3;
   localparam logic [1:0]  DMA_RUN_LAST = 2'h1;
   localparam logic [1:0]  FEA_RUN_LAST = 2'h2;
   localparam int CLK_HZ          = 40_000_000;
   localparam int CRC4_SEARCH_MS  = 8;
   localparam int CRC4_SEARCH_CYC = CRC4_SEARCH_MS * (CLK_HZ / 1000);
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> inc/e1ram_line_if.sv
`timescale 1ns/1ps
interface e1ram_line_if;
   logic bit_stb;
   logic cl_bit;
   logic ua_bit;
   logic ext_sel;
   logic cl_alarm;
   logic ua_alarm;
   modport mon (input bit_stb, cl_bit, ua_bit, ext_sel, output cl_alarm, ua_alarm);
   modport ctl (output bit_stb, cl_bit, ua_bit, ext_sel, input cl_alarm, ua_alarm);
endinterface

// >>> core/e1ram_line_mon.sv
`timescale 1ns/1ps
module e1ram_line_mon
   import e1ram_pkg::*;
(
   // Clock and reset
   input  wire logic   clk,
   input  wire logic   reset_n,
   // Line bits and alarms
   e1ram_line_if.mon   lif
);
   typedef struct packed {
      logic [11:0] zrun;
      logic [7:0]  clwin;
      logic [5:0]  clones;
      logic        cl;
      logic [8:0]  uawin;
      logic [1:0]  uazero;
      logic        ua;
   } e1ram_lm_t;

   e1ram_lm_t   s;
   e1ram_lm_t   n;
   logic [11:0] zlim;

   assign lif.cl_alarm = s.cl;
   assign lif.ua_alarm = s.ua;

   // ------------------------------------------------------------
   // Carrier loss and unframed all ones
   // ------------------------------------------------------------
   always_comb begin
      n = s;
      zlim = lif.ext_sel ? CL_ZEROS_EXT : CL_ZEROS_STD;
      if (lif.bit_stb) begin
         if (lif.cl_bit) begin
            n.zrun = '0;
         end else if (s.zrun != 12'hFFF) begin
            n.zrun = s.zrun + 12'h001;
         end
         if (!s.cl) begin
            if (!lif.cl_bit && s.zrun == zlim - 12'h001) begin
               n.cl     = 1'b1;
               n.clwin  = '0;
               n.clones = '0;
            end
         end else begin
            n.clwin = s.clwin + 8'h01;
            if (lif.cl_bit) begin
               n.clones = s.clones + 6'h01;
            end
            // Release as soon as the ones arrive, not at window end
            if (lif.cl_bit && s.clones == CL_ONES_REL - 6'h01) begin
               n.cl = 1'b0;
            end else if (s.clwin == CL_WIN_LAST) begin
               n.clwin  = '0;
               n.clones = '0;
            end
         end
         n.uawin = s.uawin + 9'h001;
         if (!lif.ua_bit && s.uazero != UA_ZEROS) begin
            n.uazero = s.uazero + 2'h1;
         end
         if (s.uawin == UA_WIN_LAST) begin
            n.ua     = n.uazero < UA_ZEROS;
            n.uazero = '0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_cl_declare: assert property (
      lif.bit_stb && !lif.cl_bit && !s.cl && s.zrun == zlim - 12'h001 |=> s.cl)
      else $error("carrier loss not declared at zero limit");
   a_cl_release: assert property (
      s.cl && lif.bit_stb && lif.cl_bit && s.clones == 6'h1F |=> !s.cl)
      else $error("carrier loss not released at 32 ones");
   a_ua_window: assert property (
      lif.bit_stb && s.uawin == UA_WIN_LAST && s.uazero == 2'h0 |=> s.ua)
      else $error("unframed all ones missed on quiet window");
endmodule

// >>> core/e1ram_top.sv
`timescale 1ns/1ps
module e1ram_top
   import e1ram_pkg::*;
#(
   parameter int CRC4_CYC = CRC4_SEARCH_CYC
)(
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RESET_N,
   // AXI4-Lite write
   input  wire logic [7:0]  AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   // AXI4-Lite read
   input  wire logic [7:0]  ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY,
   // Line bits, one strobe per bit time
   input  wire logic        BIT_STB,
   input  wire logic        RX_POSITIVE_INPUT,
   input  wire logic        RX_NEGATIVE_INPUT,
   input  wire logic        LINE_INPUT_TIP,
   input  wire logic        LINE_INPUT_RING,
   // Framer
   input  wire logic        TS16_STB,
   input  wire logic [3:0]  TS16_FRAME,
   input  wire logic [7:0]  TS16_DATA,
   input  wire logic        NAF_STB,
   input  wire logic [7:0]  NAF_DATA,
   input  wire logic        SIG_CHANGE,
   input  wire logic        RX_SLIP_EVENT,
   input  wire logic        FRAMER_ALIGNED,
   input  wire logic        CRC4_SEARCHING,
   input  wire logic        CRC4_ALIGNED,
   // Interrupt
   output logic             INT_N
);
   localparam int CTW = $clog2(CRC4_CYC);
   localparam logic [CTW-1:0] CT_LAST = CTW'(CRC4_CYC - 1);

   typedef struct packed {
      logic [7:0]     ctrl;
      logic [7:0]     mask;
      logic [7:0]     flag;
      logic [7:0]     pend;
      logic           irq_n;
      logic [3:0]     prv;
      logic           sa1;
      logic           sa0;
      logic [1:0]     mf_zero;
      logic           mf_one;
      logic           dma;
      logic [1:0]     dma_run;
      logic           fea;
      logic [1:0]     fea_run;
      logic [5:0]     csc;
      logic [CTW-1:0] ctim;
      logic           aw_held;
      logic [7:0]     awaddr;
      logic           w_held;
      logic [7:0]     wdata;
      logic           wen;
      logic           awrdy;
      logic           wrdy;
      logic           bvalid;
      logic [1:0]     bresp;
      logic           arrdy;
      logic           rvalid;
      logic [7:0]     rdata;
      logic [1:0]     rresp;
   } e1ram_st_t;

   e1ram_st_t  s;
   e1ram_st_t  n;
   logic       rd_stat;
   logic [3:0] ts_zero;
   logic [2:0] mz;
   logic       one_any;
   logic       bit_dma;
   logic       bit_fea;
   logic [3:0] lvl;
   logic [7:0] set_v;
   logic [7:0] pend_v;

   e1ram_line_if lif ();

   assign lif.bit_stb = BIT_STB;
   // Test mode swaps analog pins for the recovered digital pair
   assign lif.cl_bit  = s.ctrl[CB_CLTEST] ?
                        (RX_POSITIVE_INPUT | RX_NEGATIVE_INPUT) :
                        (LINE_INPUT_TIP | LINE_INPUT_RING);
   assign lif.ua_bit  = RX_POSITIVE_INPUT | RX_NEGATIVE_INPUT;
   assign lif.ext_sel = s.ctrl[CB_EXTCL];

   e1ram_line_mon u_line (
      .clk     (CLK),
      .reset_n (RESET_N),
      .lif     (lif)
   );

   assign AWREADY = s.awrdy;
   assign WREADY  = s.wrdy;
   assign BVALID  = s.bvalid;
   assign BRESP   = s.bresp;
   assign ARREADY = s.arrdy;
   assign RVALID  = s.rvalid;
   assign RRESP   = s.rresp;
   assign RDATA   = {24'h000000, s.rdata};
   assign INT_N   = s.irq_n;

   // ------------------------------------------------------------
   // Timeslot 16 zero count
   // ------------------------------------------------------------
   always_comb begin
      ts_zero = 4'h0;
      for (int i = 0; i < 8; i++) begin
         ts_zero = ts_zero + {3'h0, ~TS16_DATA[i]};
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      n = s;
      rd_stat = 1'b0;
      mz = 3'h0;
      one_any = 1'b0;
      bit_dma = TS16_DATA[TS16_DMA_POS];
      bit_fea = NAF_DATA[NAF_FEA_POS];
      // Register bus, write side
      if (AWVALID && s.awrdy) begin
         n.aw_held = 1'b1;
         n.awaddr  = AWADDR;
      end
      if (WVALID && s.wrdy) begin
         n.w_held = 1'b1;
         n.wdata  = WDATA[7:0];
         n.wen    = WSTRB[0];
      end
      if (s.bvalid && BREADY) begin
         n.bvalid = 1'b0;
      end
      if (s.aw_held && s.w_held && !s.bvalid) begin
         n.aw_held = 1'b0;
         n.w_held  = 1'b0;
         n.bvalid  = 1'b1;
         n.bresp   = RESP_OKAY;
         case (s.awaddr)
            A_CTRL: begin
               if (s.wen) begin
                  n.ctrl = s.wdata & CTRL_BITS;
               end
            end
            A_MASK: begin
               if (s.wen) begin
                  n.mask = s.wdata;
               end
            end
            A_STATUS, A_SYNC: n.bresp = RESP_OKAY;
            default: n.bresp = RESP_SLVERR;
         endcase
      end
      // Only one write in flight; ready drops until the response goes
      n.awrdy = !n.aw_held && !n.bvalid;
      n.wrdy  = !n.w_held && !n.bvalid;
      // Register bus, read side
      if (s.rvalid && RREADY) begin
         n.rvalid = 1'b0;
      end
      if (ARVALID && s.arrdy) begin
         n.rvalid = 1'b1;
         n.rresp  = RESP_OKAY;
         case (ARADDR)
            A_STATUS: begin
               n.rdata = s.flag;
               rd_stat = 1'b1;
            end
            A_CTRL: n.rdata = s.ctrl;
            A_MASK: n.rdata = s.mask;
            A_SYNC: n.rdata = {s.csc[5:2], s.csc[0], 3'h0};
            default: begin
               n.rdata = 8'h00;
               n.rresp = RESP_SLVERR;
            end
         endcase
      end
      n.arrdy = !n.rvalid;
      // Signaling multiframe, evaluated regardless of CAS/CCS mode
      if (TS16_STB) begin
         mz = (TS16_FRAME == 4'h0) ? 3'h0 : {1'b0, s.mf_zero};
         mz = mz + ((ts_zero > 4'h3) ? 3'h3 : ts_zero[2:0]);
         if (mz > 3'h3) begin
            mz = 3'h3;
         end
         one_any = (|TS16_DATA) | ((TS16_FRAME != 4'h0) && s.mf_one);
         n.mf_zero = mz[1:0];
         n.mf_one  = one_any;
         if (TS16_FRAME == MF_LAST) begin
            n.sa1 = mz[1:0] < SA1_ZEROS;
            n.sa0 = !one_any;
         end
         if (TS16_FRAME == 4'h0) begin
            if (bit_dma == s.dma) begin
               n.dma_run = 2'h0;
            end else if (s.dma_run == DMA_RUN_LAST) begin
               n.dma     = bit_dma;
               n.dma_run = 2'h0;
            end else begin
               n.dma_run = s.dma_run + 2'h1;
            end
         end
      end
      // Far-end alarm on the non-align frame
      if (NAF_STB) begin
         if (bit_fea == s.fea) begin
            n.fea_run = 2'h0;
         end else if (s.fea_run == FEA_RUN_LAST) begin
            n.fea     = bit_fea;
            n.fea_run = 2'h0;
         end else begin
            n.fea_run = s.fea_run + 2'h1;
         end
      end
      // CRC4 search counter
      if (!s.ctrl[CB_CRC4] || CRC4_ALIGNED) begin
         n.csc  = 6'h00;
         n.ctim = '0;
      end else if (CRC4_SEARCHING) begin
         if (s.ctim == CT_LAST) begin
            n.ctim = '0;
            n.csc  = s.csc + 6'h01;
         end else begin
            n.ctim = s.ctim + CTW'(1);
         end
      end
      // Level alarms: unframed ones, far end, carrier, alignment
      lvl = {lif.ua_alarm, n.fea, lif.cl_alarm, !FRAMER_ALIGNED};
      n.prv = lvl;
      set_v = {n.sa1 | SIG_CHANGE, n.dma, n.sa0 | SIG_CHANGE,
               RX_SLIP_EVENT, lvl};
      pend_v = {(n.sa1 & !s.sa1) | SIG_CHANGE, n.dma & !s.dma,
                (n.sa0 & !s.sa0) | SIG_CHANGE, RX_SLIP_EVENT,
                lvl ^ s.prv};
      // New events are ORed in after the read clear
      n.flag = set_v | (rd_stat ? 8'h00 : s.flag);
      n.pend = pend_v | (rd_stat ? 8'h00 : s.pend);
      n.irq_n = !(|(n.pend & s.mask));
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         s       <= '0;
         s.ctrl  <= CTRL_RST;
         s.mask  <= MASK_RST;
         s.irq_n <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   sequence s_read_status;
      ARVALID && s.arrdy && ARADDR == A_STATUS;
   endsequence

   sequence s_timeout;
      s.ctrl[CB_CRC4] && !CRC4_ALIGNED && CRC4_SEARCHING && s.ctim == CT_LAST;
   endsequence

   a_csc_step: assert property (
      s_timeout |=> s.csc == $past(s.csc) + 6'h01)
      else $error("search counter did not step on timeout");
   a_csc_sync: assert property (
      CRC4_ALIGNED |=> s.csc == 6'h00)
      else $error("search counter not cleared on alignment");
   a_csc_mode: assert property (
      !s.ctrl[CB_CRC4] |=> s.csc == 6'h00 && s.ctim == '0)
      else $error("search counter not cleared with mode off");
   a_los_flag: assert property (
      !FRAMER_ALIGNED |=> s.flag[SB_LOS])
      else $error("alignment loss flag not set");
   a_sig_both: assert property (
      SIG_CHANGE |=> s.flag[SB_SA1] && s.flag[SB_SA0])
      else $error("signaling change did not set both flags");
   a_set_wins: assert property (
      s_read_status ##0 RX_SLIP_EVENT |=> s.flag[SB_SLIP] && s.pend[SB_SLIP])
      else $error("slip lost during status read");
   a_ev_release: assert property (
      s_read_status ##0 !RX_SLIP_EVENT
      |=> !s.flag[SB_SLIP] && !s.pend[SB_SLIP])
      else $error("slip event not released by read");
   a_irq_mask: assert property (
      s.mask == 8'h00 |=> s.irq_n)
      else $error("interrupt raised with all sources masked");
   a_irq_chg: assert property (
      s.mask[SB_LOS] && FRAMER_ALIGNED != $past(FRAMER_ALIGNED)
      |=> !s.irq_n)
      else $error("alignment change did not interrupt");
endmodule

// >>> dv/e1ram_partner.sv
`timescale 1ns/1ps
module e1ram_partner (
   // Clock
   input  wire logic clk,
   // Line bits
   output logic       bit_stb = 1'h0,
   output logic       pos = 1'h0,
   output logic       neg = 1'h0,
   output logic       tip = 1'h0,
   output logic       ring = 1'h0,
   // Framer stream
   output logic       ts16_stb = 1'h0,
   output logic [3:0] ts16_frame = 4'h0,
   output logic [7:0] ts16_data = 8'h00,
   output logic       naf_stb = 1'h0,
   output logic [7:0] naf_data = 8'h00
);
   // ----------
   // Line bits
   // ----------
   // Marks flip between strobes so a stale level is never taken for data
   task automatic bits(input int n, input logic t, input logic d);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         bit_stb <= 1'h1;
         tip     <= t & !i[0];
         ring    <= t & i[0];
         pos     <= d & i[0];
         neg     <= d & !i[0];
         @(posedge clk);
         bit_stb <= 1'h0;
         tip     <= !tip;
         ring    <= !ring;
         pos     <= !pos;
         neg     <= !neg;
      end
   endtask
   // ----------
   // Framer
   // ----------
   task automatic mf(input logic [7:0] f0, input logic [7:0] d);
      for (int f = 0; f < 16; f++) begin
         @(posedge clk);
         ts16_stb   <= 1'h1;
         ts16_frame <= 4'(f);
         ts16_data  <= (f == 0) ? f0 : d;
         @(posedge clk);
         ts16_stb  <= 1'h0;
         ts16_data <= ~ts16_data;
      end
   endtask
   task automatic naf(input logic b);
      @(posedge clk);
      naf_stb  <= 1'h1;
      naf_data <= {2'h1, b, 5'h15};
      @(posedge clk);
      naf_stb  <= 1'h0;
      naf_data <= ~naf_data;
   endtask
endmodule

// >>> dv/e1ram_top_tb_top.sv
`timescale 1ns/1ps
module e1ram_top_tb_top
   import e1ram_pkg::*;
;
   // ----------
   // Signals
   // ----------
   localparam int CYC = 16;
   logic        clk = 1'h0, reset_n = 1'h0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic        arvalid = 1'h0, rready = 1'h0;
   logic        sig = 1'h0, slip = 1'h0, aligned = 1'h0;
   logic        srch = 1'h0, crc_ok = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid, int_n;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic        stb, pos, neg, tip, ring, ts_stb, naf_stb;
   logic [3:0]  ts_fr;
   logic [7:0]  ts_d, naf_d, rd_val;
   int          num_errors = 0, comparisons = 0;

   e1ram_top #(.CRC4_CYC(CYC)) i_e1ram_top (
      .CLK(clk), .RESET_N(reset_n), .AWADDR(awaddr), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid),
      .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
      .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
      .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .BIT_STB(stb),
      .RX_POSITIVE_INPUT(pos), .RX_NEGATIVE_INPUT(neg), .LINE_INPUT_TIP(tip),
      .LINE_INPUT_RING(ring), .TS16_STB(ts_stb), .TS16_FRAME(ts_fr),
      .TS16_DATA(ts_d), .NAF_STB(naf_stb), .NAF_DATA(naf_d), .SIG_CHANGE(sig),
      .RX_SLIP_EVENT(slip), .FRAMER_ALIGNED(aligned), .CRC4_SEARCHING(srch),
      .CRC4_ALIGNED(crc_ok), .INT_N(int_n)
   );
   e1ram_partner i_e1ram_partner (
      .clk(clk), .bit_stb(stb), .pos(pos), .neg(neg), .tip(tip), .ring(ring),
      .ts16_stb(ts_stb), .ts16_frame(ts_fr), .ts16_data(ts_d),
      .naf_stb(naf_stb), .naf_data(naf_d)
   );
   initial begin
      forever #12.5 clk = ~clk;
   end
   // ----------
   // Tasks
   // ----------
   task automatic end_of_test();
      if (num_errors == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic tmo(input int n);
      if (n >= 200) begin
         num_errors++;
         $display("Error handshake expected answer seen none");
         end_of_test();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
      int n;
      n = 0;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      do begin
         @(posedge clk);
         n++;
         if (awready === 1'h1) awvalid <= 1'h0;
         if (wready === 1'h1) wvalid <= 1'h0;
      end while (bvalid !== 1'h1 && n < 200);
      bready <= 1'h0;
      tmo(n);
      chk("bresp", e, bresp);
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] e);
      int n;
      n = 0;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'h1;
      rready  <= 1'h1;
      do begin
         @(posedge clk);
         n++;
         if (arready === 1'h1) arvalid <= 1'h0;
      end while (rvalid !== 1'h1 && n < 200);
      rready <= 1'h0;
      rd_val = rdata[7:0];
      tmo(n);
      chk("rresp", e, rresp);
      chk("rdata_hi", 32'h0, {8'h00, rdata[31:8]});
   endtask
   task automatic rc(input string s, input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] e);
      rd(a, RESP_OKAY);
      chk(s, e, rd_val & m);
   endtask
   // First read drops latched history, second shows the live level
   task automatic lvl(input logic [7:0] m, input logic [7:0] e);
      rd(A_STATUS, RESP_OKAY);
      rc("status", A_STATUS, m, e);
   endtask
   task automatic ick(input logic e);
      repeat (4) @(posedge clk);
      chk("int_n", e, int_n);
   endtask
   task automatic slp();
      @(posedge clk);
      slip <= 1'h1;
      @(posedge clk);
      slip <= 1'h0;
   endtask
   task automatic rst();
      @(posedge clk);
      reset_n <= 1'h0;
      repeat (5) @(posedge clk);
      reset_n <= 1'h1;
      repeat (2) @(posedge clk);
   endtask
   // Host holds each search for n cycles; the longest run wraps the 6-bit search counter
   task automatic search(input int n);
      @(posedge clk);
      srch <= 1'h1;
      repeat (n) @(posedge clk);
      srch <= 1'h0;
   endtask
   // ----------
   // Sequence
   // ----------
   initial begin
      rst();
      rc("mask", A_MASK, 8'hFF, MASK_RST);
      rc("ctrl", A_CTRL, 8'hFF, CTRL_RST);
      rc("sync", A_SYNC, 8'hFF, 8'h00);
      rd(8'h04, RESP_SLVERR);
      wr(8'h04, 8'h00, RESP_SLVERR);
      wr(A_MASK, 8'h0F, RESP_OKAY);
      ick(1'h0);
      rc("status", A_STATUS, 8'hFF, 8'h01);
      ick(1'h1);
      aligned <= 1'h1;
      ick(1'h0);
      rc("status", A_STATUS, 8'hFF, 8'h01);
      rc("status", A_STATUS, 8'hFF, 8'h00);
      ick(1'h1);
      slp();
      ick(1'h1);
      rc("status", A_STATUS, 8'h10, 8'h10);
      wr(A_MASK, 8'h10, RESP_OKAY);
      slp();
      ick(1'h0);
      rc("status", A_STATUS, 8'hFF, 8'h10);
      ick(1'h1);
      // Slip held across a status read must survive the clear
      slip <= 1'h1;
      rc("status", A_STATUS, 8'h10, 8'h10);
      slip <= 1'h0;
      ick(1'h0);
      rc("status", A_STATUS, 8'h10, 8'h10);
      ick(1'h1);
      @(posedge clk);
      sig <= 1'h1;
      @(posedge clk);
      sig <= 1'h0;
      rc("status", A_STATUS, 8'hA0, 8'hA0);
      i_e1ram_partner.mf(8'hFF, 8'hFF);
      lvl(8'hE0, 8'h80);
      i_e1ram_partner.mf(8'hFF, 8'hFF);
      lvl(8'hE0, 8'hC0);
      i_e1ram_partner.mf(8'hF8, 8'hFF);
      lvl(8'hE0, 8'h40);
      i_e1ram_partner.mf(8'hFA, 8'hFF);
      lvl(8'hE0, 8'h80);
      i_e1ram_partner.mf(8'h00, 8'h00);
      lvl(8'hE0, 8'h20);
      i_e1ram_partner.mf(8'h00, 8'h01);
      lvl(8'hE0, 8'h00);
      repeat (2) i_e1ram_partner.naf(1'h1);
      lvl(8'h04, 8'h00);
      i_e1ram_partner.naf(1'h1);
      lvl(8'h04, 8'h04);
      repeat (2) i_e1ram_partner.naf(1'h0);
      lvl(8'h04, 8'h04);
      i_e1ram_partner.naf(1'h0);
      lvl(8'h04, 8'h00);
      rst();
      i_e1ram_partner.bits(254, 1'h0, 1'h0);
      lvl(8'h02, 8'h00);
      i_e1ram_partner.bits(1, 1'h0, 1'h0);
      lvl(8'h02, 8'h02);
      i_e1ram_partner.bits(31, 1'h1, 1'h1);
      lvl(8'h02, 8'h02);
      i_e1ram_partner.bits(1, 1'h1, 1'h1);
      lvl(8'h02, 8'h00);
      rst();
      i_e1ram_partner.bits(510, 1'h1, 1'h1);
      i_e1ram_partner.bits(2, 1'h0, 1'h0);
      lvl(8'h08, 8'h08);
      i_e1ram_partner.bits(509, 1'h1, 1'h1);
      i_e1ram_partner.bits(3, 1'h0, 1'h0);
      lvl(8'h08, 8'h00);
      rst();
      wr(A_CTRL, 8'h02, RESP_OKAY);
      i_e1ram_partner.bits(2047, 1'h0, 1'h0);
      lvl(8'h02, 8'h00);
      i_e1ram_partner.bits(1, 1'h0, 1'h0);
      lvl(8'h02, 8'h02);
      rst();
      wr(A_CTRL, 8'h04, RESP_OKAY);
      i_e1ram_partner.bits(300, 1'h0, 1'h1);
      lvl(8'h02, 8'h00);
      i_e1ram_partner.bits(255, 1'h1, 1'h0);
      lvl(8'h02, 8'h02);
      rst();
      wr(A_CTRL, 8'hFF, RESP_OKAY);
      rc("ctrl", A_CTRL, 8'hFF, CTRL_BITS);
      search(6 * CYC + 8);
      rc("sync", A_SYNC, 8'hFF, 8'h10);
      @(posedge clk);
      crc_ok <= 1'h1;
      repeat (2) @(posedge clk);
      crc_ok <= 1'h0;
      rc("sync", A_SYNC, 8'hFF, 8'h00);
      rst();
      wr(A_CTRL, 8'h01, RESP_OKAY);
      search(65 * CYC + 8);
      rc("sync", A_SYNC, 8'hFF, 8'h08);
      search(3 * CYC);
      rc("sync", A_SYNC, 8'hFF, 8'h10);
      wr(A_CTRL, 8'h00, RESP_OKAY);
      rc("sync", A_SYNC, 8'hFF, 8'h00);
      end_of_test();
   end
endmodule
